// >>> hdl/ccc_pkg.sv
package ccc_pkg;

  typedef enum logic [2:0] {
    CCC_POR    = 3'h0,
    CCC_WAIT   = 3'h1,
    CCC_CONFIG = 3'h3,
    CCC_INIT   = 3'h2,
    CCC_USER   = 3'h6,
    CCC_RESET  = 3'h7,
    CCC_ERROR  = 3'h5
  } ccc_state_e;

  typedef struct packed {
    logic chain_en_n;
    logic reconfig_n;
    logic status_in;
    logic done_in;
    logic por_sel;
    logic pullup_dis;
    logic [3:0] scheme;
  } ccc_pins_s;

endpackage : ccc_pkg

// >>> hdl/ccc_regs.svh
// Behaviour
// (RULE1) Board holds chain enable low during JTAG
// (RULE2) Drive chain enable out low when done
// (RULE3) Shared lines make chain enter user together
// (RULE4) JTAG success drives chain enable out low
// (RULE5) Host keeps device within first 17 positions
// (RULE6) Select 12 ms or 100 ms power-on delay
// (RULE7) Pull-up control input gates weak pull-ups
// (RULE8) Scheme chosen from static 4-bit select
// (RULE9) Reconfig low in user mode resets, tri-states
// (RULE10) Reconfig returning high starts new configuration
// (RULE11) Status low from power-up until delay ends
// (RULE12) Configuration error pulls status line low
// (RULE13) External status low while configuring means error
// (RULE14) User mode ignores status line transitions
// (RULE15) Host holds reconfig low until supplies stable
// (RULE16) Done line low until data complete, initialization
// (RULE17) Host applies 299 clocks after last bit
// (RULE18) Configure only while chain enable input low
`ifndef CCC_REGS_SVH
`define CCC_REGS_SVH

`define CCC_CLK_MHZ 100
`define CCC_POR_FAST_MS 12
`define CCC_POR_SLOW_MS 100
`define CCC_INIT_CYCLES 299
`define CCC_CNT_W 24
`define CCC_SYNC_W 10

`define CCC_CTRL_OFS 32'h0000_0000
`define CCC_STAT_OFS 32'h0000_0004
`define CCC_IRQ_STAT_OFS 32'h0000_0008
`define CCC_IRQ_MASK_OFS 32'h0000_000c

`define CCC_CTRL_RECONF_BIT 0
`define CCC_CTRL_HOLD_BIT 1
`define CCC_CTRL_RESET 2'h0

`define CCC_IRQ_USER_BIT 0
`define CCC_IRQ_ERR_BIT 1
`define CCC_IRQ_RECONF_BIT 2
`define CCC_IRQ_W 3

`define CCC_STAT_STATE_LSB 0
`define CCC_STAT_CHAIN_BIT 3
`define CCC_STAT_DONE_BIT 4
`define CCC_STAT_STATUS_BIT 5
`define CCC_STAT_SCHEME_LSB 8

`endif

// >>> hdl/ccc_sync.sv
`timescale 1ns/100ps
`default_nettype none
`include "ccc_regs.svh"

module ccc_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Asynchronous pins and their synchronised copies
  input wire logic [`CCC_SYNC_W-1:0] async_in,
  output logic [`CCC_SYNC_W-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < `CCC_SYNC_W; i = i + 1) begin : g_bit
      logic meta_reg;
      logic sync_reg;
      // First stage feeds only the second stage
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= async_in[i];
          sync_reg <= meta_reg;
        end
      end
      assign sync_out[i] = sync_reg;
    end
  endgenerate

endmodule : ccc_sync

`default_nettype wire

// >>> hdl/ccc_top.sv
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "ccc_regs.svh"

module ccc_top
  import ccc_pkg::*;
#(
  parameter int unsigned POR_FAST_CYCLES = `CCC_POR_FAST_MS * 1000 * `CCC_CLK_MHZ,
  parameter int unsigned POR_SLOW_CYCLES = `CCC_POR_SLOW_MS * 1000 * `CCC_CLK_MHZ
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Configuration pins
  input wire logic chain_enable_in_n,
  input wire logic reconfig_req_n,
  input wire logic por_delay_select,
  input wire logic io_pullup_disable,
  input wire logic [3:0] scheme_select,
  output logic chain_enable_out_n,
  // Open-drain status and done lines
  input wire logic config_status_line_in,
  output logic config_status_line_out,
  output logic config_status_line_oe,
  input wire logic config_done_line_in,
  output logic config_done_line_out,
  output logic config_done_line_oe,
  // Configuration engine side
  input wire logic cfg_data_done,
  input wire logic cfg_data_err,
  input wire logic jtag_cfg_ok,
  output logic config_active,
  output logic [3:0] active_scheme,
  output logic user_mode,
  output logic io_pullup_en,
  output logic io_tristate,
  // Interrupt
  output logic irq
);

  localparam logic [`CCC_CNT_W-1:0] FAST_LAST = `CCC_CNT_W'(POR_FAST_CYCLES - 1);
  localparam logic [`CCC_CNT_W-1:0] SLOW_LAST = `CCC_CNT_W'(POR_SLOW_CYCLES - 1);
  localparam logic [`CCC_CNT_W-1:0] INIT_LAST = `CCC_CNT_W'(`CCC_INIT_CYCLES - 1);

  ccc_pins_s pins_async;
  ccc_pins_s pins;

  assign pins_async = '{chain_en_n: chain_enable_in_n, reconfig_n: reconfig_req_n,
                        status_in: config_status_line_in, done_in: config_done_line_in,
                        por_sel: por_delay_select, pullup_dis: io_pullup_disable,
                        scheme: scheme_select};

  ccc_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(pins_async),
    .sync_out(pins)
  );

  ccc_state_e state_reg, state_next;
  logic [`CCC_CNT_W-1:0] cnt_reg, cnt_next;
  logic [3:0] scheme_reg, scheme_next;
  logic chain_n_reg, chain_n_next;
  logic status_oe_reg, status_oe_next;
  logic done_oe_reg, done_oe_next;
  logic active_reg, active_next;
  logic user_reg, user_next;
  logic pullup_reg, pullup_next;
  logic tri_reg, tri_next;
  logic [1:0] ctrl_reg, ctrl_next;
  logic [`CCC_IRQ_W-1:0] istat_reg, istat_next;
  logic [`CCC_IRQ_W-1:0] imask_reg, imask_next;
  logic irq_reg, irq_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [1:0] warm_reg, warm_next;

  logic setup;
  logic access;
  logic mapped;
  logic wr_en;
  logic sw_reconf;
  logic reconf_low;
  logic [31:0] rdata;
  logic [`CCC_IRQ_W-1:0] events;

  // Bus decode
  always_comb begin
    setup = psel && !penable;
    access = psel && penable && pready_reg;
    mapped = (paddr == `CCC_CTRL_OFS) || (paddr == `CCC_STAT_OFS) ||
             (paddr == `CCC_IRQ_STAT_OFS) || (paddr == `CCC_IRQ_MASK_OFS);
    wr_en = access && pwrite && mapped;
    sw_reconf = wr_en && (paddr == `CCC_CTRL_OFS) && pwdata[`CCC_CTRL_RECONF_BIT];
    reconf_low = !pins.reconfig_n || sw_reconf;
    rdata = 32'h0;
    unique case (paddr)
      `CCC_CTRL_OFS: rdata[1:0] = ctrl_reg;
      `CCC_STAT_OFS: begin
        rdata[`CCC_STAT_STATE_LSB +: 3] = state_reg;
        rdata[`CCC_STAT_CHAIN_BIT] = chain_n_reg;
        rdata[`CCC_STAT_DONE_BIT] = pins.done_in;
        rdata[`CCC_STAT_STATUS_BIT] = pins.status_in;
        rdata[`CCC_STAT_SCHEME_LSB +: 4] = scheme_reg;
      end
      `CCC_IRQ_STAT_OFS: rdata[`CCC_IRQ_W-1:0] = istat_reg;
      `CCC_IRQ_MASK_OFS: rdata[`CCC_IRQ_W-1:0] = imask_reg;
      default: rdata = 32'h0;
    endcase
  end

  // Configuration sequencer
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    scheme_next = scheme_reg;
    chain_n_next = chain_n_reg;
    unique case (state_reg)
      CCC_POR: begin
        cnt_next = cnt_reg + `CCC_CNT_W'(1);
        // (RULE6) delay per select
        if (cnt_reg >= (pins.por_sel ? FAST_LAST : SLOW_LAST)) begin
          // (RULE8) capture static scheme
          scheme_next = pins.scheme;
          cnt_next = '0;
          state_next = CCC_WAIT;
        end
      end
      CCC_WAIT: begin
        // (RULE18) wait for chain enable
        // Status must read back high first: just after release the synchroniser
        // still shows the line low, which would look like an external error
        if (!pins.chain_en_n && pins.status_in && !ctrl_reg[`CCC_CTRL_HOLD_BIT]) begin
          state_next = CCC_CONFIG;
        end
      end
      CCC_CONFIG: begin
        // (RULE13) external status low
        if (cfg_data_err || !pins.status_in) begin
          state_next = CCC_ERROR;
        end else if (cfg_data_done || jtag_cfg_ok) begin
          state_next = CCC_INIT;
          cnt_next = '0;
        end
        // (RULE4) JTAG success enables next
        if (jtag_cfg_ok && !cfg_data_err) begin
          chain_n_next = 1'b0;
        end
      end
      CCC_INIT: begin
        if (!pins.status_in) begin
          state_next = CCC_ERROR;
        // (RULE3) shared done gates entry
        end else if (pins.done_in) begin
          cnt_next = cnt_reg + `CCC_CNT_W'(1);
          if (cnt_reg == INIT_LAST) begin
            state_next = CCC_USER;
            // (RULE2) enable next device
            chain_n_next = 1'b0;
          end
        end
      end
      // (RULE14) status line ignored here
      CCC_USER: state_next = CCC_USER;
      CCC_RESET: begin
        chain_n_next = 1'b1;
        // (RULE10) restart on release
        if (pins.reconfig_n) begin
          state_next = CCC_WAIT;
        end
      end
      CCC_ERROR: state_next = CCC_ERROR;
      default: state_next = CCC_POR;
    endcase
    // (RULE9) reconfig request resets
    if (state_reg != CCC_POR && state_reg != CCC_RESET && reconf_low) begin
      state_next = CCC_RESET;
      chain_n_next = 1'b1;
    end
  end

  // Pin and engine outputs
  always_comb begin
    // (RULE11) status low through delay
    // (RULE12) status low on error
    status_oe_next = (state_next == CCC_POR) || (state_next == CCC_ERROR) ||
                     (state_next == CCC_RESET);
    // (RULE16) done released at initialization
    done_oe_next = (state_next != CCC_INIT) && (state_next != CCC_USER);
    active_next = state_next == CCC_CONFIG;
    user_next = state_next == CCC_USER;
    // Synchronised pins read low for two edges after reset; keep pull-ups off till then
    warm_next = {warm_reg[0], 1'b1};
    // (RULE7) pull-ups before user mode
    pullup_next = warm_reg[1] && (state_next != CCC_USER) && !pins.pullup_dis;
    tri_next = state_next != CCC_USER;
  end

  // Registers, events and bus answer
  always_comb begin
    events = '0;
    events[`CCC_IRQ_USER_BIT] = (state_next == CCC_USER) && (state_reg != CCC_USER);
    events[`CCC_IRQ_ERR_BIT] = (state_next == CCC_ERROR) && (state_reg != CCC_ERROR);
    events[`CCC_IRQ_RECONF_BIT] = (state_next == CCC_RESET) && (state_reg != CCC_RESET);
    ctrl_next = ctrl_reg;
    imask_next = imask_reg;
    if (wr_en && paddr == `CCC_CTRL_OFS) begin
      ctrl_next[`CCC_CTRL_HOLD_BIT] = pwdata[`CCC_CTRL_HOLD_BIT];
    end
    if (wr_en && paddr == `CCC_IRQ_MASK_OFS) begin
      imask_next = pwdata[`CCC_IRQ_W-1:0];
    end
    // New events win over the read clear; only the bits that the read reported
    // are cleared, so an event landing after the setup cycle is not lost
    istat_next = ((access && !pwrite && paddr == `CCC_IRQ_STAT_OFS) ?
                  (istat_reg & ~prdata_reg[`CCC_IRQ_W-1:0]) : istat_reg) | events;
    irq_next = |(istat_next & imask_next);
    pready_next = setup;
    pslverr_next = setup && !mapped;
    prdata_next = (setup && !pwrite) ? rdata : 32'h0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= CCC_POR;
      cnt_reg <= '0;
      scheme_reg <= 4'h0;
      chain_n_reg <= 1'b1;
      status_oe_reg <= 1'b1;
      done_oe_reg <= 1'b1;
      active_reg <= 1'b0;
      user_reg <= 1'b0;
      pullup_reg <= 1'b0;
      tri_reg <= 1'b1;
      ctrl_reg <= `CCC_CTRL_RESET;
      istat_reg <= '0;
      imask_reg <= '0;
      irq_reg <= 1'b0;
      prdata_reg <= 32'h0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      warm_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      scheme_reg <= scheme_next;
      chain_n_reg <= chain_n_next;
      status_oe_reg <= status_oe_next;
      done_oe_reg <= done_oe_next;
      active_reg <= active_next;
      user_reg <= user_next;
      pullup_reg <= pullup_next;
      tri_reg <= tri_next;
      ctrl_reg <= ctrl_next;
      istat_reg <= istat_next;
      imask_reg <= imask_next;
      irq_reg <= irq_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      warm_reg <= warm_next;
    end
  end

  // Open-drain lines only ever drive low
  logic zero_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_reg <= 1'b0;
    end else begin
      zero_reg <= 1'b0;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign chain_enable_out_n = chain_n_reg;
  assign config_status_line_out = zero_reg;
  assign config_status_line_oe = status_oe_reg;
  assign config_done_line_out = zero_reg;
  assign config_done_line_oe = done_oe_reg;
  assign config_active = active_reg;
  assign active_scheme = scheme_reg;
  assign user_mode = user_reg;
  assign io_pullup_en = pullup_reg;
  assign io_tristate = tri_reg;
  assign irq = irq_reg;

endmodule : ccc_top

`default_nettype wire

// >>> verification/ccc_chk.sv
`timescale 1ns/100ps
`default_nettype none

module ccc_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pins and engine
  input wire logic chain_enable_in_n,
  input wire logic reconfig_req_n,
  input wire logic io_pullup_disable,
  input wire logic config_status_line_in,
  input wire logic cfg_data_err,
  input wire logic jtag_cfg_ok,
  // Observed outputs
  input wire logic chain_enable_out_n,
  input wire logic config_status_line_oe,
  input wire logic config_done_line_oe,
  input wire logic config_active,
  input wire logic user_mode,
  input wire logic io_pullup_en,
  input wire logic io_tristate
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_user; $rose(user_mode) |-> !chain_enable_out_n && !io_tristate; endproperty
  a_user: assert property (p_user)
    else $error("chain out or tristate wrong on user entry");
  property p_jtag; config_active && jtag_cfg_ok |-> ##[1:2] !chain_enable_out_n; endproperty
  a_jtag: assert property (p_jtag)
    else $error("chain out not low after jtag success");
  // Pin passes two sync flops and an output register
  property p_pull; io_pullup_en |-> !user_mode && !$past(io_pullup_disable, 3); endproperty
  a_pull: assert property (p_pull)
    else $error("pull-ups on while disabled");
  property p_rcfg; user_mode && !reconfig_req_n |-> ##[1:5] (io_tristate && !user_mode); endproperty
  a_rcfg: assert property (p_rcfg)
    else $error("reconfig request not honoured");
  property p_err; config_active && cfg_data_err |-> ##[1:2] (config_status_line_oe && !config_active); endproperty
  a_err: assert property (p_err)
    else $error("error not flagged on status");
  property p_ext; config_active && !config_status_line_in |-> ##[1:5] config_status_line_oe; endproperty
  a_ext: assert property (p_ext)
    else $error("external status low ignored");
  property p_keep; user_mode && reconfig_req_n && $past(reconfig_req_n) && $past(reconfig_req_n, 2) |=> user_mode; endproperty
  a_keep: assert property (p_keep)
    else $error("user mode left without request");
  property p_done; config_active || $rose(user_mode) |-> config_done_line_oe == config_active; endproperty
  a_done: assert property (p_done)
    else $error("done line drive wrong");
  // Pin passes two sync flops, then the state and output registers together
  property p_start; $rose(config_active) |-> !$past(chain_enable_in_n, 3); endproperty
  a_start: assert property (p_start)
    else $error("configured without chain enable");
endmodule : ccc_chk

bind ccc_top ccc_chk u_chk (.pclk, .presetn, .chain_enable_in_n, .reconfig_req_n,
  .io_pullup_disable, .config_status_line_in, .cfg_data_err, .jtag_cfg_ok,
  .chain_enable_out_n, .config_status_line_oe, .config_done_line_oe, .config_active,
  .user_mode, .io_pullup_en, .io_tristate);

`default_nettype wire

// >>> verification/ccc_partner.sv
`timescale 1ns/100ps
`default_nettype none

module ccc_partner (
  // Device drivers of the shared wires
  input wire logic st_oe,
  input wire logic st_out,
  input wire logic dn_oe,
  input wire logic dn_out,
  // Other parties
  input wire logic ext_low,
  input wire logic prev_done,
  // Levels seen by the device
  output logic st_wire,
  output logic dn_wire,
  output logic chain_in_n
);
  assign st_wire = !((st_oe && !st_out) || ext_low);
  assign dn_wire = !(dn_oe && !dn_out);
  assign chain_in_n = !prev_done;
endmodule : ccc_partner

`default_nettype wire

// >>> verification/test_config_chain_control.sv
`timescale 1ns/100ps
`default_nettype none

module test_config_chain_control;
  import ccc_pkg::*;
  typedef struct {logic w; logic [31:0] a, d, r; logic e;} ccc_row_s;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic pready, pslverr, er, chain_enable_out_n, chain_in_n, irq;
  logic config_status_line_in, config_status_line_out, config_status_line_oe;
  logic config_done_line_in, config_done_line_out, config_done_line_oe;
  logic config_active, user_mode, io_pullup_en, io_tristate;
  logic cfg_data_done = 1'h0, cfg_data_err = 1'h0, jtag_cfg_ok = 1'h0;
  logic ext_low = 1'h0, prev_done = 1'h0;
  logic [3:0] active_scheme;
  ccc_pins_s pin = {1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 4'ha};
  int mismatches = 0, num_checks = 0, cyc = 0, n;
  // Register reads and writes while still in power-on wait, starting with a status read
  ccc_row_s tbl[8] = '{'{0, 32'h4, 0, 32'h8, 0}, '{0, 32'h0, 0, 0, 0},
    '{0, 32'hc, 0, 0, 0}, '{1, 32'hc, 32'h7, 0, 0}, '{0, 32'hc, 0, 32'h7, 0},
    '{0, 32'h8, 0, 0, 0}, '{0, 32'h10, 0, 0, 1}, '{1, 32'h2, 32'h5, 0, 1}};

  always #5 pclk = ~pclk;
  always @(posedge pclk) cyc <= presetn ? cyc + 1 : 0;

  ccc_top #(.POR_FAST_CYCLES(60), .POR_SLOW_CYCLES(100)) uut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .chain_enable_in_n(chain_in_n), .reconfig_req_n(pin.reconfig_n),
    .por_delay_select(pin.por_sel), .io_pullup_disable(pin.pullup_dis),
    .scheme_select(pin.scheme), .chain_enable_out_n, .config_status_line_in,
    .config_status_line_out, .config_status_line_oe, .config_done_line_in,
    .config_done_line_out, .config_done_line_oe, .cfg_data_done, .cfg_data_err,
    .jtag_cfg_ok, .config_active, .active_scheme, .user_mode, .io_pullup_en,
    .io_tristate, .irq);
  ccc_partner far (.st_oe(config_status_line_oe), .st_out(config_status_line_out),
    .dn_oe(config_done_line_oe), .dn_out(config_done_line_out), .ext_low, .prev_done,
    .st_wire(config_status_line_in), .dn_wire(config_done_line_in), .chain_in_n);

  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", s, x, g);
    end
  endtask : chk

  // Entered just after an edge; the watchdog ends a wait that never sees pready
  task automatic apb(input logic w, input logic [31:0] a, d, output logic [31:0] r,
      output logic e);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb

  task automatic till(ref logic s, input logic v, output int c);
    c = 0;
    while (s !== v && c < 2000) begin
      @(posedge pclk);
      c++;
    end
  endtask : till

  task automatic recfg;
    pin.reconfig_n <= 1'h0;
    repeat (6) @(posedge pclk);
    pin.reconfig_n <= 1'h1;
    till(config_active, 1'h1, n);
  endtask : recfg

  task automatic pulse_edge;
    @(posedge pclk);
    cfg_data_done <= 1'h0;
    cfg_data_err <= 1'h0;
    jtag_cfg_ok <= 1'h0;
    repeat (3) @(posedge pclk);
  endtask : pulse_edge

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    pin.reconfig_n <= 1'h1;
    @(posedge pclk);
    foreach (tbl[i]) begin
      apb(tbl[i].w, tbl[i].a, tbl[i].d, rd, er);
      if (!tbl[i].w) chk("rdata", tbl[i].r, rd);
      chk("slverr", {31'h0, tbl[i].e}, er);
    end
    till(config_status_line_oe, 1'h0, n);
    chk("por fast", 1, cyc >= 60 && cyc <= 65);
    repeat (10) @(posedge pclk);
    chk("idle", 0, config_active);
    chk("pullup on", 1, io_pullup_en);
    pin.pullup_dis <= 1'h1;
    repeat (5) @(posedge pclk);
    chk("pullup off", 0, io_pullup_en);
    prev_done <= 1'h1;
    till(config_active, 1'h1, n);
    chk("scheme", 4'ha, active_scheme);
    cfg_data_done <= 1'h1;
    pulse_edge;
    chk("done release", 0, config_done_line_oe);
    chk("od low", 0, {config_status_line_out, config_done_line_out});
    till(user_mode, 1'h1, n);
    chk("init span", 1, n >= 293 && n <= 306);
    chk("chain out", 0, chain_enable_out_n);
    chk("irq", 1, irq);
    apb(0, 32'h8, 0, rd, er);
    chk("user event", 32'h1, rd);
    @(posedge pclk);
    chk("irq clear", 0, irq);
    ext_low <= 1'h1;
    repeat (10) @(posedge pclk);
    ext_low <= 1'h0;
    chk("user kept", 1, user_mode);
    pin.reconfig_n <= 1'h0;
    repeat (6) @(posedge pclk);
    chk("tristate", 1, io_tristate);
    chk("user left", 0, user_mode);
    pin.reconfig_n <= 1'h1;
    till(config_active, 1'h1, n);
    chk("restart", 1, n < 20);
    apb(0, 32'h8, 0, rd, er);
    chk("reset event", 32'h4, rd);
    cfg_data_err <= 1'h1;
    pulse_edge;
    chk("error status", 1, config_status_line_oe);
    recfg;
    jtag_cfg_ok <= 1'h1;
    pulse_edge;
    chk("jtag chain", 0, chain_enable_out_n);
    recfg;
    ext_low <= 1'h1;
    repeat (5) @(posedge pclk);
    ext_low <= 1'h0;
    chk("ext error", 1, config_status_line_oe);
    chk("ext stop", 0, config_active);
    // Software reconfigure with hold set: device must park in the wait state
    apb(1, 32'h0, 32'h3, rd, er);
    repeat (10) @(posedge pclk);
    chk("hold", 0, config_active);
    apb(0, 32'h0, 0, rd, er);
    chk("ctrl", 32'h2, rd);
    apb(1, 32'h0, 32'h0, rd, er);
    till(config_active, 1'h1, n);
    chk("hold release", 1, n < 20);
    pin.por_sel <= 1'h0;
    pin.pullup_dis <= 1'h0;
    presetn <= 1'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    till(config_status_line_oe, 1'h0, n);
    chk("por slow", 1, cyc >= 100 && cyc <= 105);
    complete_run;
  end

  initial begin
    #100000;
    mismatches++;
    complete_run;
  end
endmodule : test_config_chain_control

`default_nettype wire
